// [rtl/cfg_serial_pkg.sv]
// Purpose: Shared constants and types for the configuration serial port.
// Assumes: One fixed control byte layout, agreed with the host.
// Notes: All counts are in serial clock rising edges after pin synchronisation; the serial output moves on falling edges.
package cfg_serial_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned BANK_COUNT = 8;
  localparam int unsigned IDX_W = 3;

  // Control byte layout, bit 0 is the first bit on the line.
  localparam int unsigned RW_POS = 0;
  localparam int unsigned ADDR_LSB = 1;
  localparam logic RW_READ = 1'b1;

  localparam logic [IDX_W-1:0] FIRST_BIT = 3'h0;
  localparam logic [IDX_W-1:0] LAST_BIT = 3'h7;
  localparam logic [3:0] IDLE_CNT_ZERO = 4'h0;
  localparam logic [3:0] RESYNC_CLKS = 4'h8;

  localparam logic SDO_IDLE = 1'b0;
  localparam logic [DATA_W-1:0] BANK_RESET = 8'h00;

  typedef enum logic {
    PH_CONTROL,
    PH_DATA
  } phase_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic serial_in_line;
  } link_pins_t;

  localparam link_pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, serial_in_line: 1'b0};

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bank_write_t;

  localparam bank_write_t WRITE_IDLE = '{en: 1'b0, addr: 3'h0, data: 8'h00};

  typedef logic [BANK_COUNT-1:0][DATA_W-1:0] bank_array_t;

endpackage : cfg_serial_pkg

// [rtl/pin_sync.sv]
// Purpose: Two-stage synchroniser for the serial link pins.
// Assumes: Pins change slowly relative to the system clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module pin_sync
  import cfg_serial_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire link_pins_t pins_in,
  output link_pins_t pins_out
);

  typedef struct packed {
    link_pins_t meta;
    link_pins_t stable;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  always_comb
  begin
    nxt_st.meta = pins_in;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      st_ff <= '{meta: PINS_IDLE, stable: PINS_IDLE};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign pins_out = st_ff.stable;

endmodule : pin_sync

// [rtl/config_bank_store.sv]
// Purpose: Eight configuration banks of eight bits each.
// Assumes: A single write port driven by the serial port.
// Notes: Read data is the live bank content, so a read sees the last write.
`timescale 1ns/1ps
module config_bank_store
  import cfg_serial_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire bank_write_t wr_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out,
  output bank_array_t banks_out
);

  typedef struct packed {
    bank_array_t bank;
  } store_state_t;

  store_state_t st_ff;
  store_state_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (wr_in.en)
    begin
      nxt_st.bank[wr_in.addr] = wr_in.data;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      st_ff.bank <= {BANK_COUNT{BANK_RESET}};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data_out = st_ff.bank[rd_addr_in];
  assign banks_out = st_ff.bank;

endmodule : config_bank_store

// [rtl/config_serial_port.sv]
// Purpose: Serial slave port that reads and writes eight configuration banks.
// Assumes: Serial clock, select and input are asynchronous pins, slow against clk_in.
// Notes: Each transfer is a control byte then a data byte, both sent low bit first.
`timescale 1ns/1ps

module config_serial_port
  import cfg_serial_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic serial_clk_in,
  input wire logic chip_select_n_in,
  input wire logic serial_in_line_in,
  output logic serial_out_line_out,
  output logic serial_out_line_oe_out,
  output bank_array_t cfg_banks_out
);

  typedef struct packed {
    logic sclk_prev;
    phase_t phase;
    logic [IDX_W-1:0] bit_idx;
    logic [DATA_W-1:0] shift;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [3:0] idle_cnt;
    logic serial_out_line;
    logic sdo_oe;
    bank_write_t wr;
  } port_state_t;

  port_state_t st_ff;
  port_state_t nxt_st;
  link_pins_t raw_pins;
  link_pins_t pins;
  logic rise;
  logic fall;
  logic [DATA_W-1:0] byte_in;
  logic [DATA_W-1:0] rd_data;

  assign raw_pins = '{sclk: serial_clk_in, cs_n: chip_select_n_in, serial_in_line: serial_in_line_in};

  // All three pins share one synchroniser so their relative timing is kept.
  pin_sync u_pin_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pins_in(raw_pins),
    .pins_out(pins)
  );

  config_bank_store u_store (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(st_ff.wr),
    .rd_addr_in(st_ff.addr),
    .rd_data_out(rd_data),
    .banks_out(cfg_banks_out)
  );

  assign rise = pins.sclk & ~st_ff.sclk_prev;
  assign fall = ~pins.sclk & st_ff.sclk_prev;
  assign byte_in = {pins.serial_in_line, st_ff.shift[DATA_W-1:1]};

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.sclk_prev = pins.sclk;
    nxt_st.wr = WRITE_IDLE;
    if (pins.cs_n)
    begin
      // Nothing shifts while deselected; only the idle clocks are counted.
      nxt_st.serial_out_line = SDO_IDLE;
      nxt_st.sdo_oe = 1'b0;
      if (rise)
      begin
        // Saturating keeps a long idle run from wrapping back below the resync threshold.
        if (st_ff.idle_cnt >= RESYNC_CLKS - 4'h1)
        begin
          nxt_st.idle_cnt = RESYNC_CLKS;
          nxt_st.phase = PH_CONTROL;
          nxt_st.bit_idx = FIRST_BIT;
        end
        else
        begin
          nxt_st.idle_cnt = st_ff.idle_cnt + 4'h1;
        end
      end
    end
    else
    begin
      // A short high on select between framed bytes must not lose position.
      nxt_st.idle_cnt = IDLE_CNT_ZERO;
      if (rise)
      begin
        nxt_st.shift = byte_in;
        nxt_st.bit_idx = st_ff.bit_idx + 3'h1;
        if (st_ff.bit_idx == LAST_BIT)
        begin
          case (st_ff.phase)
            PH_CONTROL:
            begin
              nxt_st.rd = (byte_in[RW_POS] == RW_READ);
              nxt_st.addr = byte_in[ADDR_LSB +: ADDR_W];
              nxt_st.phase = PH_DATA;
            end
            PH_DATA:
            begin
              if (!st_ff.rd)
              begin
                nxt_st.wr = '{en: 1'b1, addr: st_ff.addr, data: byte_in};
              end
              nxt_st.phase = PH_CONTROL;
            end
            default:
            begin
              nxt_st.phase = PH_CONTROL;
            end
          endcase
        end
      end
      if (fall)
      begin
        if ((st_ff.phase == PH_DATA) && st_ff.rd)
        begin
          nxt_st.serial_out_line = rd_data[st_ff.bit_idx];
          nxt_st.sdo_oe = 1'b1;
        end
        else
        begin
          nxt_st.serial_out_line = SDO_IDLE;
          nxt_st.sdo_oe = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      st_ff.sclk_prev <= 1'b0;
      st_ff.phase <= PH_CONTROL;
      st_ff.bit_idx <= FIRST_BIT;
      st_ff.shift <= BANK_RESET;
      st_ff.rd <= 1'b0;
      st_ff.addr <= '0;
      st_ff.idle_cnt <= IDLE_CNT_ZERO;
      st_ff.serial_out_line <= SDO_IDLE;
      st_ff.sdo_oe <= 1'b0;
      st_ff.wr <= WRITE_IDLE;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Select gates the serial output pin, this shifter, the bank write pulse and the idle clock counter.
  assign serial_out_line_out = st_ff.serial_out_line;
  assign serial_out_line_oe_out = st_ff.sdo_oe;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_lsb_first;
    rise && !pins.cs_n |=> st_ff.shift[DATA_W-1] == $past(pins.serial_in_line)
      && st_ff.shift[DATA_W-2:0] == $past(st_ff.shift[DATA_W-1:1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("Shift not low bit first.");

  property p_sample_on_rise;
    !rise |=> $stable(st_ff.shift);
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise) else $error("Shift moved without rise.");

  property p_sdo_on_fall;
    $changed(serial_out_line_out) |-> $past(fall) || $past(pins.cs_n);
  endproperty
  a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("Output changed off a fall.");

  property p_deselect_quiet;
    pins.cs_n |=> !serial_out_line_oe_out && $stable(st_ff.shift) && !st_ff.wr.en;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet) else $error("Active while deselected.");

  property p_count_step;
    rise && !pins.cs_n |=> st_ff.bit_idx == $past(st_ff.bit_idx) + 3'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("Bit index did not step.");

  property p_control_decode;
    rise && !pins.cs_n && st_ff.bit_idx == LAST_BIT && st_ff.phase == PH_CONTROL
      |=> st_ff.phase == PH_DATA && st_ff.addr == $past(byte_in[ADDR_LSB +: ADDR_W])
      && st_ff.rd == $past(byte_in[RW_POS]);
  endproperty
  a_control_decode: assert property (p_control_decode) else $error("Control byte misdecoded.");

  property p_read_bit;
    fall && !pins.cs_n && st_ff.phase == PH_DATA && st_ff.rd
      |=> serial_out_line_oe_out && serial_out_line_out == $past(rd_data[st_ff.bit_idx]);
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("Read bit wrong.");

  property p_write_store;
    st_ff.wr.en |=> cfg_banks_out[$past(st_ff.wr.addr)] == $past(st_ff.wr.data);
  endproperty
  a_write_store: assert property (p_write_store) else $error("Write not stored.");

  property p_write_source;
    rise && !pins.cs_n && st_ff.bit_idx == LAST_BIT && st_ff.phase == PH_DATA && !st_ff.rd
      |=> st_ff.wr.en && st_ff.wr.data == $past(byte_in) ##1 !st_ff.wr.en;
  endproperty
  a_write_source: assert property (p_write_source) else $error("Write pulse wrong.");

  property p_resync;
    rise && pins.cs_n && st_ff.idle_cnt >= RESYNC_CLKS - 4'h1
      |=> st_ff.bit_idx == FIRST_BIT && st_ff.phase == PH_CONTROL;
  endproperty
  a_resync: assert property (p_resync) else $error("No resync after idle clocks.");

  property p_wrap;
    rise && !pins.cs_n && st_ff.bit_idx == LAST_BIT && st_ff.phase == PH_DATA
      |=> st_ff.phase == PH_CONTROL && st_ff.bit_idx == FIRST_BIT;
  endproperty
  a_wrap: assert property (p_wrap) else $error("No return to control byte.");

  // These checks see the pins through the synchroniser, so they trail the pin edges by a few cycles.
  property p_idle_clear;
    !pins.cs_n |=> st_ff.idle_cnt == IDLE_CNT_ZERO;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("Idle count kept while selected.");

  property p_short_gap_keeps;
    pins.cs_n && st_ff.idle_cnt < RESYNC_CLKS - 4'h1
      |=> $stable(st_ff.bit_idx) && $stable(st_ff.phase);
  endproperty
  a_short_gap_keeps: assert property (p_short_gap_keeps) else $error("Short deselect lost position.");

  property p_idle_step;
    rise && pins.cs_n && st_ff.idle_cnt < RESYNC_CLKS - 4'h1
      |=> st_ff.idle_cnt == $past(st_ff.idle_cnt) + 4'h1;
  endproperty
  a_idle_step: assert property (p_idle_step) else $error("Idle clock not counted.");

  property p_idle_hold;
    pins.cs_n && st_ff.idle_cnt == RESYNC_CLKS |=> st_ff.idle_cnt == RESYNC_CLKS;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Idle count left saturation.");

  property p_read_no_write;
    rise && !pins.cs_n && st_ff.bit_idx == LAST_BIT && st_ff.phase == PH_DATA && st_ff.rd
      |=> !st_ff.wr.en;
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("Read wrote a bank.");

  property p_drive_needs_read;
    serial_out_line_oe_out |-> st_ff.rd;
  endproperty
  a_drive_needs_read: assert property (p_drive_needs_read) else $error("Output driven outside a read.");

  property p_idle_level;
    !serial_out_line_oe_out |-> serial_out_line_out == SDO_IDLE;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("Undriven output not at idle level.");

  property p_read_end;
    fall && !pins.cs_n && st_ff.phase == PH_CONTROL |=> !serial_out_line_oe_out;
  endproperty
  a_read_end: assert property (p_read_end) else $error("Drive kept after the last data bit.");

  property p_banks_hold;
    !st_ff.wr.en |=> $stable(cfg_banks_out);
  endproperty
  a_banks_hold: assert property (p_banks_hold) else $error("Bank changed without a write.");

  property p_write_addr;
    st_ff.wr.en |-> st_ff.wr.addr == st_ff.addr;
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("Write went to another bank.");

  // Covers mark the transfers the bench is meant to reach.
  c_write: cover property (st_ff.wr.en);
  c_read_drive: cover property (serial_out_line_oe_out [*3]);
  c_resync: cover property (pins.cs_n && st_ff.idle_cnt == RESYNC_CLKS);
  c_gap_resume: cover property (rise && pins.cs_n && st_ff.phase == PH_DATA);
  c_read_end: cover property (fall && !pins.cs_n && st_ff.phase == PH_CONTROL && serial_out_line_oe_out);

endmodule : config_serial_port

// [test/serial_host_model.sv]
// Purpose: Host model that frames serial transfers to the configuration port.
// Assumes: Serial clock low 50 ns then high 30 ns, standing low between frames.
// Notes: A released input line shows the inverse of its last level.
`timescale 1ns/1ps
module serial_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in,
  input wire logic oe_in
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // The long low half leaves the port time to update its output before we sample.
  // Pins move by non-blocking assignment so the port's synchroniser never races them on a clock edge.
  task automatic pulse(input logic b, output logic so, output logic oe);
    sdi_out <= b;
    #50 sclk_out <= 1'b1;
    so = sdo_in;
    oe = oe_in;
    #30 sclk_out <= 1'b0;
  endtask : pulse

  // Select only moves while the clock is low, so the bit counter never sees a stray edge.
  task automatic shift(input logic [15:0] w, input int n, input bit keep_low, output logic [15:0] so,
                       output logic [15:0] oe);
    so = 16'h0000;
    oe = 16'h0000;
    #10 cs_n_out <= 1'b0;
    for (int i = 0; i < n; i++)
      pulse(w[i], so[i], oe[i]);
    #10;
    if (!keep_low)
      cs_n_out <= 1'b1;
    sdi_out <= ~sdi_out;
  endtask : shift

  task automatic idle(input int n);
    logic s;
    logic o;
    #10 cs_n_out <= 1'b1;
    for (int i = 0; i < n; i++)
      pulse(~sdi_out, s, o);
  endtask : idle
endmodule : serial_host_model

// [test/config_serial_port_test.sv]
// Purpose: Self-checking bench for the configuration serial port.
// Assumes: Control byte bit 0 is the read flag, bits 3:1 the bank.
// Notes: Reads are checked with select held low for the whole word.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module config_serial_port_test;
  import cfg_serial_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sclk;
  logic cs_n;
  logic serial_in_line;
  logic sdo_w;
  logic oe_w;
  bank_array_t banks;
  bank_array_t exp_banks;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;

  always #5 clk_in = ~clk_in;

  serial_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(serial_in_line), .sdo_in(sdo_w), .oe_in(oe_w));

  config_serial_port u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .serial_clk_in(sclk),
    .chip_select_n_in(cs_n), .serial_in_line_in(serial_in_line), .serial_out_line_out(sdo_w),
    .serial_out_line_oe_out(oe_w), .cfg_banks_out(banks));

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [2:0] a, input logic [7:0] d, input int gap);
    logic [15:0] so;
    logic [15:0] oe;
    if (gap == 0)
      u_host.shift({d, 4'h0, a, ~RW_READ}, 16, 1'b1, so, oe);
    else
    begin
      u_host.shift({8'h00, 4'h0, a, ~RW_READ}, 8, 1'b0, so, oe);
      u_host.idle(gap);
      u_host.shift({8'h00, d}, 8, 1'b0, so, oe);
    end
    repeat (6) @(posedge clk_in);
    exp_banks[a] = d;
    `CHK("write oe", 16'h0000, oe)
    `CHK("banks after write", exp_banks, banks)
  endtask : wr

  task automatic rd(input logic [2:0] a);
    logic [15:0] so;
    logic [15:0] oe;
    u_host.shift({8'h5a, 4'h0, a, RW_READ}, 16, 1'b1, so, oe);
    repeat (6) @(posedge clk_in);
    `CHK("read data", exp_banks[a], so[15:8])
    `CHK("read oe", 16'hff00, oe)
    `CHK("oe after read", 1'b0, oe_w)
    `CHK("banks after read", exp_banks, banks)
  endtask : rd

  task automatic t_reset;
    foreach (exp_banks[i])
      exp_banks[i] = BANK_RESET;
    `CHK("reset banks", exp_banks, banks)
    `CHK("reset oe", 1'b0, oe_w)
    $display("test reset done");
  endtask : t_reset

  task automatic t_all;
    for (int b = 0; b < 8; b++)
      wr(b[2:0], 8'h3c ^ 8'(b * 37), 0);
    for (int b = 0; b < 8; b++)
      rd(b[2:0]);
    $display("test all banks done");
  endtask : t_all

  // A few clocks with select high between bytes stand in for a free-running clock.
  task automatic t_split;
    wr(3'h6, 8'h81, 3);
    wr(3'h2, 8'h7e, 7);
    rd(3'h6);
    rd(3'h2);
    $display("test split bytes done");
  endtask : t_split

  task automatic t_resync;
    logic [15:0] so;
    logic [15:0] oe;
    u_host.shift(16'h000e, 5, 1'b0, so, oe);
    u_host.idle(8);
    repeat (6) @(posedge clk_in);
    `CHK("banks while deselected", exp_banks, banks)
    `CHK("oe while deselected", 1'b0, oe_w)
    wr(3'h1, 8'hc3, 0);
    rd(3'h1);
    $display("test resync done");
  endtask : t_resync

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_all();
    t_split();
    t_resync();
    give_verdict();
  end
endmodule : config_serial_port_test
